// ==== design/nbu_uart.sv ====
// Nine-bit asynchronous serial port with address filtering and its control register.
// Assumes a baud tick at twice the bit rate and CPU register strobes synchronous to clk.
`timescale 1ns/1ps
module nbu_uart (
    input wire logic clk,
    input wire logic reset,
    input wire logic baud_tick,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic int_enable,
    input wire logic rx_pin,
    output logic [7:0] sfr_rdata,
    output logic tx_pin,
    output logic irq
);
    import nbu_pkg::*;

    logic mode_r, mode_nxt, filt_r, filt_nxt, ren_r, ren_nxt, tb8_r, tb8_nxt;
    logic rb8_r, rb8_nxt, ti_r, ti_nxt, ri_r, ri_nxt;
    logic [7:0] rxbuf_r, rxbuf_nxt, rdata_r, rdata_nxt;
    logic irq_r, irq_nxt;
    // Transmitter state
    nbu_state_t tst_r, tst_nxt;
    logic [8:0] tsh_r, tsh_nxt;
    logic [3:0] tcnt_r, tcnt_nxt;
    logic [1:0] tph_r, tph_nxt;
    logic tx_r, tx_nxt, ti_set;
    // Receiver state
    nbu_state_t rst_r, rst_nxt;
    logic [8:0] rsh_r, rsh_nxt;
    logic [3:0] rcnt_r, rcnt_nxt;
    logic [1:0] rph_r, rph_nxt;
    logic rx_d_r, rx_d_nxt, rx_accept;
    logic [3:0] nbits;

    wire logic wr_ctrl = sfr_wr && sfr_addr == NBU_CTRL_ADDR;
    wire logic wr_data = sfr_wr && sfr_addr == NBU_DATA_ADDR;
    wire logic [7:0] ctrl_view = {mode_r, 1'b1, filt_r, ren_r, tb8_r, rb8_r, ti_r, ri_r};

    // Data bits per frame plus the optional ninth
    assign nbits = mode_r ? 4'd9 : 4'd8;

    // Transmit path
    always_comb begin
        tst_nxt = tst_r;
        tsh_nxt = tsh_r;
        tcnt_nxt = tcnt_r;
        tph_nxt = tph_r;
        tx_nxt = tx_r;
        ti_set = 1'b0;
        // A write mid-frame restarts the frame; software is expected to wait for the flag
        if (wr_data) begin
            tsh_nxt = {tb8_r, sfr_wdata};
            tst_nxt = NBU_START;
            tph_nxt = 2'd0;
            tcnt_nxt = 4'd0;
            tx_nxt = 1'b0;
        end else if (baud_tick && tst_r != NBU_IDLE) begin
            tph_nxt = tph_r + 2'd1;
            if (tph_r + 2'd1 == NBU_TICKS_PER_BIT) begin
                tph_nxt = 2'd0;
                case (tst_r)
                    NBU_START: begin
                        tst_nxt = NBU_BITS;
                        tx_nxt = tsh_r[0];
                        tsh_nxt = {1'b1, tsh_r[8:1]};
                        tcnt_nxt = 4'd1;
                    end
                    NBU_BITS: begin
                        if (tcnt_r == nbits) begin
                            tst_nxt = NBU_STOP;
                            tx_nxt = 1'b1;
                            ti_set = 1'b1;
                        end else begin
                            tx_nxt = tsh_r[0];
                            tsh_nxt = {1'b1, tsh_r[8:1]};
                            tcnt_nxt = tcnt_r + 4'd1;
                        end
                    end
                    NBU_STOP: begin
                        tst_nxt = NBU_IDLE;
                    end
                    default: begin
                        tst_nxt = NBU_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tst_r <= NBU_IDLE;
            tsh_r <= 9'h1ff;
            tcnt_r <= 4'h0;
            tph_r <= 2'h0;
            tx_r <= 1'b1;
        end else begin
            tst_r <= tst_nxt;
            tsh_r <= tsh_nxt;
            tcnt_r <= tcnt_nxt;
            tph_r <= tph_nxt;
            tx_r <= tx_nxt;
        end
    end

    // Receive path; sampling in the first half of each bit on the half-bit tick
    always_comb begin
        rst_nxt = rst_r;
        rsh_nxt = rsh_r;
        rcnt_nxt = rcnt_r;
        rph_nxt = rph_r;
        rx_d_nxt = rx_pin;
        rx_accept = 1'b0;
        case (rst_r)
            NBU_IDLE: begin
                // Falling edge starts the bit timer fresh, independent of transmit
                if (ren_r && rx_d_r && !rx_pin) begin
                    rst_nxt = NBU_START;
                    // First tick checks start; later samples land early in a bit, not on its last cycle
                    rph_nxt = {1'b0, NBU_HALF_BIT};
                end
            end
            NBU_START: begin
                if (baud_tick) begin
                    if (rph_r[0] == NBU_HALF_BIT) begin
                        rph_nxt = 2'd0;
                        // Line back high at the first tick after the edge is dropped as a glitch
                        rst_nxt = rx_pin ? NBU_IDLE : NBU_BITS;
                        rcnt_nxt = 4'd0;
                    end else begin
                        rph_nxt = rph_r + 2'd1;
                    end
                end
            end
            NBU_BITS: begin
                if (baud_tick) begin
                    rph_nxt = rph_r + 2'd1;
                    if (rph_r + 2'd1 == NBU_TICKS_PER_BIT) begin
                        rph_nxt = 2'd0;
                        rsh_nxt = mode_r ? {rx_pin, rsh_r[8:1]} : {1'b0, rx_pin, rsh_r[7:1]};
                        rcnt_nxt = rcnt_r + 4'd1;
                        if (rcnt_r + 4'd1 == nbits) begin
                            rst_nxt = NBU_STOP;
                        end
                    end
                end
            end
            NBU_STOP: begin
                if (baud_tick) begin
                    rph_nxt = rph_r + 2'd1;
                    if (rph_r + 2'd1 == NBU_TICKS_PER_BIT) begin
                        rph_nxt = 2'd0;
                        rst_nxt = NBU_IDLE;
                        if (mode_r) begin
                            rx_accept = !ri_r && (!filt_r || rsh_r[8]);
                        end else begin
                            rx_accept = !ri_r && (!filt_r || rx_pin);
                        end
                    end
                end
            end
            default: begin
                rst_nxt = NBU_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rst_r <= NBU_IDLE;
            rsh_r <= 9'h000;
            rcnt_r <= 4'h0;
            rph_r <= 2'h0;
            rx_d_r <= 1'b1;
        end else begin
            rst_r <= rst_nxt;
            rsh_r <= rsh_nxt;
            rcnt_r <= rcnt_nxt;
            rph_r <= rph_nxt;
            rx_d_r <= rx_d_nxt;
        end
    end

    // Register file
    always_comb begin
        mode_nxt = mode_r;
        filt_nxt = filt_r;
        ren_nxt = ren_r;
        tb8_nxt = tb8_r;
        rb8_nxt = rb8_r;
        ti_nxt = ti_r;
        ri_nxt = ri_r;
        rxbuf_nxt = rxbuf_r;
        rdata_nxt = rdata_r;
        if (wr_ctrl) begin
            mode_nxt = sfr_wdata[NBU_MODE_BIT];
            filt_nxt = sfr_wdata[NBU_FILT_BIT];
            ren_nxt = sfr_wdata[NBU_REN_BIT];
            tb8_nxt = sfr_wdata[NBU_TB8_BIT];
            rb8_nxt = sfr_wdata[NBU_RB8_BIT];
            ti_nxt = sfr_wdata[NBU_TI_BIT];
            ri_nxt = sfr_wdata[NBU_RI_BIT];
        end
        // Hardware set wins over a same-cycle software clear
        if (ti_set) begin
            ti_nxt = 1'b1;
        end
        if (rx_accept) begin
            rxbuf_nxt = rsh_r[7:0];
            rb8_nxt = mode_r ? rsh_r[8] : rx_pin;
            ri_nxt = 1'b1;
        end
        if (sfr_rd) begin
            rdata_nxt = sfr_addr == NBU_CTRL_ADDR ? ctrl_view : sfr_addr == NBU_DATA_ADDR ? rxbuf_r : 8'h00;
        end
        irq_nxt = int_enable && (ti_nxt || ri_nxt);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mode_r <= NBU_CTRL_RESET[NBU_MODE_BIT];
            filt_r <= NBU_CTRL_RESET[NBU_FILT_BIT];
            ren_r <= NBU_CTRL_RESET[NBU_REN_BIT];
            tb8_r <= NBU_CTRL_RESET[NBU_TB8_BIT];
            rb8_r <= NBU_CTRL_RESET[NBU_RB8_BIT];
            ti_r <= NBU_CTRL_RESET[NBU_TI_BIT];
            ri_r <= NBU_CTRL_RESET[NBU_RI_BIT];
            rxbuf_r <= NBU_DATA_RESET;
            rdata_r <= 8'h00;
            irq_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            filt_r <= filt_nxt;
            ren_r <= ren_nxt;
            tb8_r <= tb8_nxt;
            rb8_r <= rb8_nxt;
            ti_r <= ti_nxt;
            ri_r <= ri_nxt;
            rxbuf_r <= rxbuf_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign sfr_rdata = rdata_r;
    assign tx_pin = tx_r;
    assign irq = irq_r;

    sequence data_write_s;
        wr_data;
    endsequence

    sequence start_bit_s;
        !tx_pin;
    endsequence

    start_bit_drive_a: assert property (@(posedge clk) disable iff (reset) data_write_s |=> start_bit_s)
        else $error("start bit not driven after data write");
    ti_stop_begin_a: assert property (@(posedge clk) disable iff (reset)
        ti_set |=> ti_r && tx_pin && tst_r == NBU_STOP)
        else $error("transmit flag not set at stop start");
    ninth_capture_a: assert property (@(posedge clk) disable iff (reset)
        wr_data |=> tsh_r[8] == $past(tb8_r))
        else $error("ninth transmit bit not captured");
    rx_disabled_a: assert property (@(posedge clk) disable iff (reset)
        rst_r == NBU_IDLE && !ren_r |=> rst_r == NBU_IDLE)
        else $error("receiver started while disabled");
    accept_guard_a: assert property (@(posedge clk) disable iff (reset)
        rx_accept |-> !ri_r && (!filt_r || (mode_r ? rsh_r[8] : rx_pin)))
        else $error("frame accepted against conditions");
    accept_load_a: assert property (@(posedge clk) disable iff (reset)
        rx_accept |=> ri_r && rxbuf_r == $past(rsh_r[7:0]))
        else $error("accepted frame not loaded");
    ninth_store_a: assert property (@(posedge clk) disable iff (reset)
        rx_accept && mode_r |=> rb8_r == $past(rsh_r[8]))
        else $error("ninth receive bit wrong");
    stop_store_a: assert property (@(posedge clk) disable iff (reset)
        rx_accept && !mode_r |=> rb8_r == $past(rx_pin))
        else $error("stop bit not stored in eight-bit mode");
    flag_hold_a: assert property (@(posedge clk) disable iff (reset)
        ri_r && !wr_ctrl |=> ri_r)
        else $error("receive flag cleared by hardware");
    filter_drop_a: assert property (@(posedge clk) disable iff (reset)
        filt_r && mode_r && !ri_r && !wr_ctrl && rst_r == NBU_STOP && !rsh_r[8] |=> !ri_r)
        else $error("data frame raised indication while filtering");
    irq_follow_a: assert property (@(posedge clk) disable iff (reset)
        int_enable && $rose(ti_r) |-> irq)
        else $error("interrupt not raised for flag");
    overrun_keep_a: assert property (@(posedge clk) disable iff (reset)
        ri_r |=> rxbuf_r == $past(rxbuf_r))
        else $error("receive buffer overwritten while flag set");
endmodule

// ==== design/nbu_pkg.sv ====
// Package for the nine-bit serial port: register addresses, field positions, reset values, states.
// Assumes an 8-bit special-function register space reached by address, read and write strobes.
package nbu_pkg;
    localparam logic [7:0] NBU_CTRL_ADDR = 8'h98;
    localparam logic [7:0] NBU_DATA_ADDR = 8'h99;
    localparam logic [7:0] NBU_CTRL_RESET = 8'h40;
    localparam logic [7:0] NBU_DATA_RESET = 8'h00;
    localparam int NBU_MODE_BIT = 7;
    localparam int NBU_FIXED_BIT = 6;
    localparam int NBU_FILT_BIT = 5;
    localparam int NBU_REN_BIT = 4;
    localparam int NBU_TB8_BIT = 3;
    localparam int NBU_RB8_BIT = 2;
    localparam int NBU_TI_BIT = 1;
    localparam int NBU_RI_BIT = 0;
    localparam int NBU_DATA_BITS = 8;
    // Ticks per bit: the baud tick arrives at twice the bit rate
    localparam logic [1:0] NBU_TICKS_PER_BIT = 2'd2;
    localparam logic [0:0] NBU_HALF_BIT = 1'd1;
    typedef enum logic [1:0] {
        NBU_IDLE = 2'b00,
        NBU_START = 2'b01,
        NBU_BITS = 2'b11,
        NBU_STOP = 2'b10
    } nbu_state_t;
endpackage

// ==== testbench/nbu_node.sv ====
// Remote serial node: sends frames to the port and captures frames from it.
// Assumes a baud tick at twice the bit rate; its line changes at the falling clock edge.
`timescale 1ns/1ps
module nbu_node (
    input wire logic clk,
    input wire logic baud_tick,
    input wire logic rx_line,
    input wire logic mark,
    output logic tx_line
);
    initial tx_line = 1'b1;
    task automatic tk();
        do @(posedge clk); while (baud_tick !== 1'b1);
    endtask
    task automatic bit_out(input logic b);
        @(negedge clk);
        tx_line = b;
        tk();
        tk();
    endtask
    // Trailing idle bit keeps frames apart
    task automatic send(input logic [7:0] d, input logic b9, input logic nine, input logic stop);
        bit_out(1'b0);
        for (int i = 0; i < 8; i++) begin
            bit_out(d[i]);
        end
        if (nine) begin
            bit_out(b9);
        end
        bit_out(stop);
        bit_out(1'b1);
    endtask
    // End of start bit is the timing reference, so data bit 0 must be high
    task automatic grab(output logic [9:0] bits, output logic [9:0] marks);
        int n;
        n = 0;
        while (rx_line !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        while (rx_line !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        tk();
        for (int i = 0; i < 10; i++) begin
            @(negedge clk);
            bits[i] = rx_line;
            marks[i] = mark;
            tk();
            tk();
        end
    endtask
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the nine-bit serial port.
// Assumes the remote node model drives the receive line and watches the transmit line.
`timescale 1ns/1ps
module tb;
    import nbu_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic baud_tick = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic int_enable = 1'b1;
    logic rx_pin;
    logic [7:0] sfr_rdata;
    logic tx_pin;
    logic irq;
    logic [1:0] tick_cnt = 2'h0;
    int fails = 0;
    int cmp_count = 0;
    nbu_uart i_nbu_uart (.clk(clk), .reset(reset), .baud_tick(baud_tick), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .int_enable(int_enable),
        .rx_pin(rx_pin), .sfr_rdata(sfr_rdata), .tx_pin(tx_pin), .irq(irq));
    nbu_node i_nbu_node (.clk(clk), .baud_tick(baud_tick), .rx_line(tx_pin), .mark(irq),
        .tx_line(rx_pin));
    always #5 clk = ~clk;
    // Tick every fourth cycle: eight cycles a bit keeps the run short
    always @(negedge clk) begin
        tick_cnt <= tick_cnt + 2'h1;
        baud_tick <= (tick_cnt == 2'h3);
    end
    task automatic close_out();
        if (fails == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        @(negedge clk);
        chk(sfr_rdata, e);
    endtask
    task automatic irqchk(input logic e);
        repeat (2) @(negedge clk);
        chk({7'h00, irq}, {7'h00, e});
    endtask
    task automatic rx(input logic [7:0] d, input logic b9, input logic stop, input logic [7:0] ec,
        input logic [7:0] ed);
        i_nbu_node.send(d, b9, ec[7], stop);
        rdchk(NBU_CTRL_ADDR, ec);
        rdchk(NBU_DATA_ADDR, ed);
    endtask
    task automatic t_regs();
        rdchk(NBU_CTRL_ADDR, 8'h40);
        rdchk(8'h55, 8'h00);
        wr(NBU_CTRL_ADDR, 8'h00);
        wr(8'h55, 8'hff);
        rdchk(NBU_CTRL_ADDR, 8'h40);
    endtask
    // Ninth transmit bit is cleared mid-frame; the frame must keep the captured one
    task automatic t_tx(input logic nine, input logic [7:0] d);
        logic [9:0] b;
        logic [9:0] m;
        logic [7:0] c;
        c = {nine, 7'h00};
        wr(NBU_CTRL_ADDR, c | 8'h08);
        wr(NBU_DATA_ADDR, d);
        wr(NBU_CTRL_ADDR, c);
        i_nbu_node.grab(b, m);
        chk(b[7:0], d);
        chk({6'h00, b[9:8]}, 8'h03);
        chk({5'h00, m[9:7]}, nine ? 8'h04 : 8'h06);
        rdchk(NBU_CTRL_ADDR, c | 8'h42);
        irqchk(1'b1);
        wr(NBU_CTRL_ADDR, c);
        irqchk(1'b0);
    endtask
    task automatic t_rx9();
        wr(NBU_CTRL_ADDR, 8'h80);
        rx(8'h3c, 1'b1, 1'b0, 8'hc0, 8'h00);
        wr(NBU_CTRL_ADDR, 8'h90);
        rx(8'h3c, 1'b1, 1'b0, 8'hd5, 8'h3c);
        irqchk(1'b1);
        rx(8'hc3, 1'b0, 1'b1, 8'hd5, 8'h3c);
    endtask
    task automatic t_filt();
        wr(NBU_CTRL_ADDR, 8'hb0);
        rx(8'h11, 1'b0, 1'b1, 8'hf0, 8'h3c);
        rx(8'h22, 1'b1, 1'b1, 8'hf5, 8'h22);
        wr(NBU_CTRL_ADDR, 8'h30);
        rx(8'h44, 1'b0, 1'b0, 8'h70, 8'h22);
        rx(8'h55, 1'b0, 1'b1, 8'h75, 8'h55);
        @(negedge clk);
        int_enable = 1'b0;
        irqchk(1'b0);
        int_enable = 1'b1;
        wr(NBU_CTRL_ADDR, 8'h10);
        rx(8'h66, 1'b0, 1'b0, 8'h51, 8'h66);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        t_regs();
        t_tx(1'b1, 8'ha5);
        t_tx(1'b0, 8'h33);
        t_rx9();
        t_filt();
        close_out();
    end
    // About 1,050 cycles expected; the limit leaves a wide margin
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        close_out();
    end
endmodule
